// ---- rtl/sfpe_top.sv ----
// program/erase command sequencer of a serial nor flash
// assumes: sclk_i only toggles while sel_n_i is low; protect/quad bits come
// from status logic on mclk_i; the array behind arr_* takes one byte per write
//
// How it works
// - page program: opcode, 24-bit address, data bytes
// - one to 256 bytes, one page only
// - program/erase need write latch set first
// - byte address wraps to page start
// - over 256 bytes: later bytes overwrite earlier
// - partial program leaves other page bytes alone
// - select must rise right after whole byte
// - valid program starts timed program cycle
// - busy flag high during cycle, low after
// - status stays readable while busy
// - write latch cleared when cycle completes
// - protected target address blocks the operation
// - quad program needs quad enable set
// - quad program: data on four lines
// - sector erase sets 4 Kbyte to ones
// - half block erase sets 32 Kbyte
// - full block erase sets 64 Kbyte
// - erases run for their own timed lengths
`timescale 1ns/1ps
module sfpe_top
   import sfpe_pkg::*;
#(
   parameter int PROGRAM_TIME_NS          = PROGRAM_TIME_NS_DEF,
   parameter int SECTOR_ERASE_TIME_NS     = SECT_ERASE_TIME_NS_DEF,
   parameter int HALF_BLOCK_ERASE_TIME_NS = HALF_ERASE_TIME_NS_DEF,
   parameter int FULL_BLOCK_ERASE_TIME_NS = FULL_ERASE_TIME_NS_DEF
) (
   // system clock and reset
   input  wire logic              mclk_i,
   input  wire logic              sys_rst_i,
   // serial link
   input  wire logic              sclk_i,
   input  wire logic              sel_n_i,
   input  wire logic              serial_in_pin_i,
   input  wire logic [2:0]        quad_dq_i,       // data lines 3..1
   // configuration bits
   input  wire logic              quad_enable_bit_i,
   input  wire logic              protect_complement_bit_i,
   input  wire logic              small_unit_select_bit_i,
   input  wire logic              top_bottom_select_bit_i,
   input  wire logic [2:0]        protect_range_bits_i,
   // status bits
   output logic                   operation_in_progress_flag_o,
   output logic                   write_latch_flag_o,
   // array port
   output logic                   arr_wr_o,
   output logic                   arr_erase_o,
   output sfpe_erase_t            arr_erase_kind_o,
   output logic [ADDR_W-1:0]      arr_addr_o,
   output logic [7:0]             arr_data_o
);

   // ----------------------------------------------------------------
   // cycle counts
   // ----------------------------------------------------------------
   localparam int WALK_MIN   = PAGE_BYTES + 4;
   localparam int PROG_RAW   = PROGRAM_TIME_NS / CLK_PERIOD_NS;
   localparam int PROG_CYC   = (PROG_RAW > WALK_MIN) ? PROG_RAW : WALK_MIN;
   localparam int SECT_RAW   = SECTOR_ERASE_TIME_NS / CLK_PERIOD_NS;
   localparam int SECT_CYC   = (SECT_RAW > 1) ? SECT_RAW : 1;
   localparam int HALF_RAW   = HALF_BLOCK_ERASE_TIME_NS / CLK_PERIOD_NS;
   localparam int HALF_CYC   = (HALF_RAW > 1) ? HALF_RAW : 1;
   localparam int FULL_RAW   = FULL_BLOCK_ERASE_TIME_NS / CLK_PERIOD_NS;
   localparam int FULL_CYC   = (FULL_RAW > 1) ? FULL_RAW : 1;

   // ----------------------------------------------------------------
   // link domain state
   // ----------------------------------------------------------------
   logic                  fresh;       // no edge seen yet in this frame
   logic [5:0]            hdr_cnt;
   logic [7:0]            opcode;
   logic [ADDR_W-1:0]     addr;
   logic [7:0]            shift;
   logic [2:0]            sub;
   logic [PAGE_AW-1:0]    byte_idx;
   logic                  got_byte;
   logic [PAGE_BYTES-1:0] byte_mask;
   logic                  busy_s1;
   logic                  busy_l;
   logic                  hdr_done;
   logic                  quad_op;
   logic                  byte_done;
   logic [7:0]            next_byte;
   logic                  buf_we;

   // ----------------------------------------------------------------
   // system domain state
   // ----------------------------------------------------------------
   logic                  sel_s1;
   logic                  sel_s2;
   logic                  sel_s3;
   logic                  frame_end;
   sfpe_state_t           state;
   logic [31:0]           timer;
   logic [8:0]            rd_idx;
   logic                  rd_vld;
   logic [PAGE_AW-1:0]    rd_idx_q;
   logic [7:0]            rd_data;
   logic                  write_latch;
   logic                  cmd8_ok;
   logic                  full_ok;
   logic                  prog_op;
   logic                  erase_op;
   logic [4:0]            unit_aw;
   logic [ARRAY_AW-1:0]   unit_lo;
   logic [ARRAY_AW-1:0]   unit_hi;
   logic                  prot_blk;
   logic                  start_prog;
   logic                  start_erase;

   // ----------------------------------------------------------------
   // protection lookup
   // ----------------------------------------------------------------
   // true when the byte address sits in the write-protected area
   function automatic logic prot_hit(input logic [ARRAY_AW-1:0] a);
      logic [4:0] lg;
      logic       all;
      logic       in_rng;
      lg  = PROT_BIG_BASE;
      all = 1'b0;
      if (small_unit_select_bit_i) begin
         lg = (PROT_SMALL_BASE + {2'b00, protect_range_bits_i} > PROT_SMALL_MAX) ?
              PROT_SMALL_MAX : PROT_SMALL_BASE + {2'b00, protect_range_bits_i};
      end else if (protect_range_bits_i >= PROT_ALL_RANGE) begin
         all = 1'b1;
      end else begin
         lg = PROT_BIG_BASE + {2'b00, protect_range_bits_i};
      end
      if (top_bottom_select_bit_i) begin
         in_rng = ((a >> lg) == '0);
      end else begin
         in_rng = ((a >> lg) == ({ARRAY_AW{1'b1}} >> lg));
      end
      if (protect_range_bits_i == 3'h0) begin
         in_rng = 1'b0;
      end else if (all) begin
         in_rng = 1'b1;
      end
      return in_rng ^ protect_complement_bit_i;
   endfunction

   // ----------------------------------------------------------------
   // link: frame front end on the serial clock
   // ----------------------------------------------------------------
   // select high presets the frame marker; the clock may stop between frames
   always_ff @(posedge sclk_i or posedge sel_n_i) begin
      if (sel_n_i) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   // busy level into the link domain; only needed once data bytes arrive
   always_ff @(posedge sclk_i) begin
      busy_s1 <= operation_in_progress_flag_o;
      busy_l  <= busy_s1;
   end

   assign hdr_done  = !fresh && (hdr_cnt == HDR_BITS);
   assign quad_op   = (opcode == OP_QUAD_PROGRAM);
   assign byte_done = hdr_done && (quad_op ? (sub == 3'd1) : (sub == 3'd7));
   assign next_byte = quad_op ? {shift[3:0], quad_dq_i, serial_in_pin_i}
                              : {shift[6:0], serial_in_pin_i};
   assign buf_we    = byte_done && !busy_l &&
                      (opcode == OP_PAGE_PROGRAM || quad_op);

   // header: opcode then address, msb first
   always_ff @(posedge sclk_i) begin
      if (fresh) begin
         hdr_cnt <= 6'd1;
      end else if (hdr_cnt != HDR_BITS) begin
         hdr_cnt <= hdr_cnt + 6'd1;
      end
      if (fresh || hdr_cnt < OPC_BITS) begin
         opcode <= {opcode[6:0], serial_in_pin_i};
      end
      if (!fresh && hdr_cnt >= OPC_BITS && hdr_cnt < HDR_BITS) begin
         addr <= {addr[ADDR_W-2:0], serial_in_pin_i};
      end
   end

   // data bytes: one bit or one nibble per edge
   always_ff @(posedge sclk_i) begin
      if (!hdr_done || byte_done) begin
         sub <= 3'd0;
      end else begin
         sub <= sub + 3'd1;
      end
      if (hdr_done) begin
         shift <= next_byte;
      end
   end

   // page offset walks within the page only; wrap replaces old bytes
   always_ff @(posedge sclk_i) begin
      if (!fresh && hdr_cnt == HDR_BITS - 6'd1) begin
         byte_idx <= {addr[PAGE_AW-2:0], serial_in_pin_i};
      end else if (byte_done) begin
         byte_idx <= byte_idx + 8'h01;
      end
   end

   // which page bytes this frame supplied; untouched bytes stay out
   always_ff @(posedge sclk_i) begin
      if (fresh) begin
         got_byte  <= 1'b0;
         byte_mask <= '0;
      end else if (buf_we) begin
         got_byte            <= 1'b1;
         byte_mask[byte_idx] <= 1'b1;
      end
   end

   sfpe_page_buf #(
      .W     (8),
      .DEPTH (PAGE_BYTES),
      .AW    (PAGE_AW)
   ) u_page_buf (
      .wr_clk_i  (sclk_i),
      .wr_en_i   (buf_we),
      .wr_addr_i (byte_idx),
      .wr_data_i (next_byte),
      .rd_clk_i  (mclk_i),
      .rd_addr_i (rd_idx[PAGE_AW-1:0]),
      .rd_data_o (rd_data)
   );

   // ----------------------------------------------------------------
   // system: end of frame and command decode
   // ----------------------------------------------------------------
   // select synchroniser; the third stage only feeds the edge detect
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sel_s1 <= 1'b1;
         sel_s2 <= 1'b1;
         sel_s3 <= 1'b1;
      end else begin
         sel_s1 <= sel_n_i;
         sel_s2 <= sel_s1;
         sel_s3 <= sel_s2;
      end
   end

   // link fields are quasi-static here: no serial edge after select rises
   // the frame marker is already preset by select high, so only counts are read;
   // limitation: a frame with no clock edges re-offers the previous fields
   assign frame_end = sel_s2 && !sel_s3;
   assign cmd8_ok   = hdr_cnt == OPC_BITS;
   assign full_ok   = hdr_cnt == HDR_BITS && sub == 3'd0;
   assign prog_op   = (opcode == OP_PAGE_PROGRAM) ||
                      (quad_op && quad_enable_bit_i);
   assign erase_op  = (opcode == OP_SECTOR_ERASE) ||
                      (opcode == OP_HALF_BLOCK_ERASE) ||
                      (opcode == OP_FULL_BLOCK_ERASE);

   // erase unit size; program checks its single page
   always_comb begin
      case (opcode)
         OP_SECTOR_ERASE:     unit_aw = SECT_AW;
         OP_HALF_BLOCK_ERASE: unit_aw = HALF_BLOCK_AW;
         OP_FULL_BLOCK_ERASE: unit_aw = FULL_BLOCK_AW;
         default:             unit_aw = 5'(PAGE_AW);
      endcase
   end

   assign unit_lo  = addr[ARRAY_AW-1:0] & ~(({ARRAY_AW{1'b1}}) >> (5'(ARRAY_AW) - unit_aw)
                     << 0);
   assign unit_hi  = unit_lo | ({ARRAY_AW{1'b1}} >> (5'(ARRAY_AW) - unit_aw));
   // a process, so protect bit changes re-run the lookup as well
   always_comb begin
      prot_blk = prot_hit(unit_lo) || prot_hit(unit_hi);
   end

   assign start_prog  = state == ST_IDLE && frame_end && full_ok && got_byte &&
                        prog_op && write_latch && !prot_blk;
   assign start_erase = state == ST_IDLE && frame_end && full_ok && !got_byte &&
                        erase_op && write_latch && !prot_blk;

   // ----------------------------------------------------------------
   // system: write latch
   // ----------------------------------------------------------------
   // commands arriving during a cycle are dropped, latch included
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         write_latch <= WRITE_LATCH_RST;
      end else if (state == ST_WAIT && timer == 32'h0) begin
         write_latch <= 1'b0;
      end else if (state == ST_IDLE && frame_end && cmd8_ok) begin
         if (opcode == OP_WRITE_ENABLE) begin
            write_latch <= 1'b1;
         end else if (opcode == OP_WRITE_DISABLE) begin
            write_latch <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // system: self-timed cycle
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state <= ST_IDLE;
         timer <= 32'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_prog) begin
                  state <= ST_WALK;
                  timer <= 32'(PROG_CYC - 1);
               end else if (start_erase) begin
                  state <= ST_WAIT;
                  case (opcode)
                     OP_SECTOR_ERASE:     timer <= 32'(SECT_CYC - 1);
                     OP_HALF_BLOCK_ERASE: timer <= 32'(HALF_CYC - 1);
                     default:             timer <= 32'(FULL_CYC - 1);
                  endcase
               end
            end
            ST_WALK: begin
               timer <= timer - 32'h1;
               if (rd_idx == 9'(PAGE_BYTES)) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (timer == 32'h0) begin
                  state <= ST_IDLE;
               end else begin
                  timer <= timer - 32'h1;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // page walk: read index, then one cycle of buffer latency
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rd_idx   <= 9'h0;
         rd_vld   <= 1'b0;
         rd_idx_q <= 8'h00;
      end else begin
         rd_vld   <= state == ST_WALK && rd_idx != 9'(PAGE_BYTES);
         rd_idx_q <= rd_idx[PAGE_AW-1:0];
         if (state != ST_WALK) begin
            rd_idx <= 9'h0;
         end else if (rd_idx != 9'(PAGE_BYTES)) begin
            rd_idx <= rd_idx + 9'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // status is plain flops, readable at any time including mid-cycle
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         operation_in_progress_flag_o <= 1'b0;
      end else begin
         // falls on the same edge as the write latch, never after it
         operation_in_progress_flag_o <= (state != ST_IDLE &&
                                          !(state == ST_WAIT && timer == 32'h0)) ||
                                         start_prog || start_erase;
      end
   end

   assign write_latch_flag_o = write_latch;

   // array strobes; only bytes supplied in the frame are written
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         arr_wr_o         <= 1'b0;
         arr_erase_o      <= 1'b0;
         arr_erase_kind_o <= ERASE_SECTOR;
         arr_addr_o       <= 24'h000000;
         arr_data_o       <= 8'h00;
      end else begin
         arr_wr_o    <= rd_vld && byte_mask[rd_idx_q];
         arr_erase_o <= start_erase;
         if (rd_vld) begin
            arr_addr_o <= {addr[ADDR_W-1:PAGE_AW], rd_idx_q};
            arr_data_o <= rd_data;
         end else if (start_erase) begin
            arr_addr_o <= {addr[ADDR_W-1:ARRAY_AW], unit_lo};
            case (opcode)
               OP_SECTOR_ERASE:     arr_erase_kind_o <= ERASE_SECTOR;
               OP_HALF_BLOCK_ERASE: arr_erase_kind_o <= ERASE_HALF;
               default:             arr_erase_kind_o <= ERASE_FULL;
            endcase
         end
      end
   end

endmodule

// ---- rtl/sfpe_pkg.sv ----
// shared constants and types for the serial flash program/erase sequencer
// assumes a 25 MHz system clock; the serial clock comes from the bus host
package sfpe_pkg;

   // ----------------------------------------------------------------
   // clocking and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS          = 40;
   localparam int PROGRAM_TIME_NS_DEF    = 1000000;   // plain default, no figure given
   localparam int SECT_ERASE_TIME_NS_DEF = 50000000;
   localparam int HALF_ERASE_TIME_NS_DEF = 150000000;
   localparam int FULL_ERASE_TIME_NS_DEF = 250000000;

   // ----------------------------------------------------------------
   // opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_ENABLE     = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE    = 8'h04;
   localparam logic [7:0] OP_PAGE_PROGRAM     = 8'h02;
   localparam logic [7:0] OP_QUAD_PROGRAM     = 8'h32;
   localparam logic [7:0] OP_SECTOR_ERASE     = 8'h20;
   localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
   localparam logic [7:0] OP_FULL_BLOCK_ERASE = 8'hd8;

   // ----------------------------------------------------------------
   // frame layout and geometry
   // ----------------------------------------------------------------
   localparam logic [5:0] OPC_BITS      = 6'd8;
   localparam logic [5:0] HDR_BITS      = 6'd32;   // opcode plus 24 address bits
   localparam int         ADDR_W        = 24;
   localparam int         PAGE_AW       = 8;
   localparam int         PAGE_BYTES    = 256;
   localparam int         ARRAY_AW      = 21;      // 2 Mbyte array
   localparam logic [4:0] SECT_AW       = 5'd12;
   localparam logic [4:0] HALF_BLOCK_AW = 5'd15;
   localparam logic [4:0] FULL_BLOCK_AW = 5'd16;

   // ----------------------------------------------------------------
   // protection region sizes (log2 of bytes)
   // ----------------------------------------------------------------
   localparam logic [4:0] PROT_SMALL_BASE = 5'd11;  // small units: range 1 -> 4 Kbyte
   localparam logic [4:0] PROT_SMALL_MAX  = 5'd15;
   localparam logic [4:0] PROT_BIG_BASE   = 5'd15;  // blocks: range 1 -> 64 Kbyte
   localparam logic [2:0] PROT_ALL_RANGE  = 3'd6;

   // ----------------------------------------------------------------
   // reset values and types
   // ----------------------------------------------------------------
   localparam logic WRITE_LATCH_RST = 1'b0;

   typedef enum logic [1:0] {ERASE_SECTOR, ERASE_HALF, ERASE_FULL} sfpe_erase_t;
   typedef enum logic [1:0] {ST_IDLE, ST_WALK, ST_WAIT} sfpe_state_t;

endpackage

// ---- rtl/sfpe_page_buf.sv ----
// page data buffer: written from the serial clock, read from the system clock
// assumes writes and reads never overlap in time (frame ends before the walk)
`timescale 1ns/1ps
module sfpe_page_buf #(
   parameter int W     = 8,
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   // write side, serial clock
   input  wire logic          wr_clk_i,
   input  wire logic          wr_en_i,
   input  wire logic [AW-1:0] wr_addr_i,
   input  wire logic [W-1:0]  wr_data_i,
   // read side, system clock
   input  wire logic          rd_clk_i,
   input  wire logic [AW-1:0] rd_addr_i,
   output logic      [W-1:0]  rd_data_o
);

   logic [W-1:0] mem [DEPTH];

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   // write port, no reset: contents are qualified by a separate mask
   always_ff @(posedge wr_clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   // registered read port
   always_ff @(posedge rd_clk_i) begin
      rd_data_o <= mem[rd_addr_i];
   end

endmodule

// ---- dv/sfpe_properties.sv ----
// concurrent checks on the program/erase sequencer top ports
// assumes binding to sfpe_top, one system clock domain
`timescale 1ns/1ps
module sfpe_checker
   import sfpe_pkg::*;
(
   // watched ports
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        sel_n_i,
   input  wire logic        operation_in_progress_flag_o,
   input  wire logic        write_latch_flag_o,
   input  wire logic        arr_wr_o,
   input  wire logic        arr_erase_o,
   input  wire sfpe_erase_t arr_erase_kind_o,
   input  wire logic [23:0] arr_addr_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_write_when_busy: assert property (arr_wr_o |-> operation_in_progress_flag_o)
      else $error("array write outside busy");
   a_erase_when_busy: assert property (arr_erase_o |-> operation_in_progress_flag_o)
      else $error("erase outside busy");
   a_erase_one_pulse: assert property (arr_erase_o |=> !arr_erase_o [*8])
      else $error("erase pulse repeated");
   a_busy_has_latch: assert property (operation_in_progress_flag_o |-> write_latch_flag_o)
      else $error("busy without write latch");
   a_latch_clears_end: assert property ($fell(operation_in_progress_flag_o) |-> !write_latch_flag_o)
      else $error("latch kept after cycle");
   a_erase_unit_base: assert property (arr_erase_o |->
      (arr_erase_kind_o == ERASE_SECTOR && arr_addr_o[11:0] == 12'h000) ||
      (arr_erase_kind_o == ERASE_HALF && arr_addr_o[14:0] == 15'h0000) ||
      (arr_erase_kind_o == ERASE_FULL && arr_addr_o[15:0] == 16'h0000))
      else $error("erase base not aligned");
   a_busy_min_span: assert property ($rose(operation_in_progress_flag_o) |-> operation_in_progress_flag_o [*8])
      else $error("busy too short");
   a_busy_after_sel: assert property ($rose(operation_in_progress_flag_o) |-> sel_n_i && $past(sel_n_i, 2))
      else $error("busy before select rise");
   a_latch_after_sel: assert property ($rose(write_latch_flag_o) |-> sel_n_i && !operation_in_progress_flag_o)
      else $error("latch set mid frame");
   // main scenarios reached
   c_write: cover property (arr_wr_o);
   c_full_erase: cover property (arr_erase_o && arr_erase_kind_o == ERASE_FULL);
   c_done: cover property ($fell(operation_in_progress_flag_o));
endmodule

bind sfpe_top sfpe_checker u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sel_n_i(sel_n_i),
   .operation_in_progress_flag_o(operation_in_progress_flag_o),
   .write_latch_flag_o(write_latch_flag_o), .arr_wr_o(arr_wr_o), .arr_erase_o(arr_erase_o),
   .arr_erase_kind_o(arr_erase_kind_o), .arr_addr_o(arr_addr_o));

// ---- dv/sfpe_host.sv ----
// serial bus host model sending command frames
// assumes 80 ns serial clock, stopped low between frames
`timescale 1ns/1ps
module sfpe_host (
   // serial link
   output logic       sclk_o,
   output logic       sel_n_o,
   output logic       dq0_o,
   output logic [2:0] dq_o
);
   initial begin
      sclk_o = 1'b0;
      sel_n_o = 1'b0;
      dq0_o = 1'b0;
      dq_o = 3'h0;
      #1 sel_n_o = 1'b1;  // a real rising edge presets the frame marker
   end
   // one bit per rising serial clock, data set while low
   task automatic clk_bit(input logic b, input logic [2:0] v);
      dq0_o = b;
      dq_o = v;
      #40 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
   endtask
   // nb header bits, then nd bytes; bytes past 256 inverted so overwrite shows
   task automatic send(input logic [7:0] op, input logic [23:0] ad, input int nb,
                       input int nd, input logic q, input logic [7:0] d0);
      logic [31:0] h;
      logic [7:0]  d;
      h = {op, ad};
      #7 sel_n_o = 1'b0;  // select held low the whole frame
      #40;
      for (int i = 0; i < nb; i++) clk_bit(i < 32 ? h[31-i] : 1'b0, 3'h5);
      for (int j = 0; j < nd; j++) begin
         d = d0 + j[7:0];
         if (j > 255) d = ~d;
         if (q) begin  // high nibble first on four lines
            clk_bit(d[4], d[7:5]);
            clk_bit(d[0], d[3:1]);
         end else for (int k = 7; k >= 0; k--) clk_bit(d[k], 3'h5);
      end
      #40 sel_n_o = 1'b1;  // rises after the last bit sent, whole byte or not
      dq0_o = ~dq0_o;  // released lines never keep the last value
      dq_o = ~dq_o;
      #200;
   endtask
endmodule

// ---- dv/sfpe_top_bench.sv ----
// self-checking bench for the program/erase sequencer
// assumes short timing parameters: 500/100/200/300 busy cycles
`timescale 1ns/1ps
module sfpe_top_bench;
   import sfpe_pkg::*;
   logic mclk_i = 1'b0, sys_rst_i = 1'b1, quad_en = 1'b0, cmp_b = 1'b0, sec_b = 1'b0, tb_b = 1'b0;
   logic [2:0] range_b = 3'h0, dq;
   logic sclk, sel_n, dq0, busy, latch, wr, er;
   sfpe_erase_t kind;
   logic [23:0] addr;
   logic [7:0] data;
   logic [31:0] wq[$], eq[$];
   int fail_count = 0, total_checks = 0, bc = 0;
   always #20 mclk_i = ~mclk_i;
   sfpe_host u_host (.sclk_o(sclk), .sel_n_o(sel_n), .dq0_o(dq0), .dq_o(dq));
   sfpe_top #(.PROGRAM_TIME_NS(20000), .SECTOR_ERASE_TIME_NS(4000),
      .HALF_BLOCK_ERASE_TIME_NS(8000), .FULL_BLOCK_ERASE_TIME_NS(12000)) u_dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .sel_n_i(sel_n),
      .serial_in_pin_i(dq0), .quad_dq_i(dq), .quad_enable_bit_i(quad_en),
      .protect_complement_bit_i(cmp_b), .small_unit_select_bit_i(sec_b),
      .top_bottom_select_bit_i(tb_b), .protect_range_bits_i(range_b),
      .operation_in_progress_flag_o(busy), .write_latch_flag_o(latch), .arr_wr_o(wr),
      .arr_erase_o(er), .arr_erase_kind_o(kind), .arr_addr_o(addr), .arr_data_o(data));
   // array port monitor and busy span counter
   always @(posedge mclk_i) begin
      if (wr === 1'b1) wq.push_back({addr, data});
      if (er === 1'b1) eq.push_back({6'h00, kind, addr});
      if (busy === 1'b1) bc++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // optional write enable, one frame, then wait for idle under a bound
   task automatic cmd(input logic w, input logic [7:0] op, input logic [23:0] ad, input int nb,
                      input int nd, input logic q, input logic [7:0] d0);
      int n;
      n = 0;
      if (w) u_host.send(OP_WRITE_ENABLE, 24'h0, 8, 0, 1'b0, 8'h00);
      wq.delete();
      eq.delete();
      bc = 0;
      u_host.send(op, ad, nb, nd, q, d0);
      repeat (10) @(negedge mclk_i);
      while (busy !== 1'b0 && n < 800) begin
         @(negedge mclk_i);
         n++;
      end
   endtask
   task automatic t_refusals();
      cmd(1'b0, OP_SECTOR_ERASE, 24'h001000, 32, 0, 1'b0, 8'h00);
      check(bc, 0);
      cmd(1'b1, OP_SECTOR_ERASE, 24'h001000, 33, 0, 1'b0, 8'h00);
      check({bc, latch}, 1);
      range_b = 3'h6;
      cmd(1'b1, OP_SECTOR_ERASE, 24'h001000, 32, 0, 1'b0, 8'h00);
      check(bc + eq.size(), 0);
      range_b = 3'h0;
      cmd(1'b0, OP_WRITE_DISABLE, 24'h0, 8, 0, 1'b0, 8'h00);
      check(latch, 0);
   endtask
   task automatic t_erase();
      logic [7:0]  ops[3] = '{OP_SECTOR_ERASE, OP_HALF_BLOCK_ERASE, OP_FULL_BLOCK_ERASE};
      logic [23:0] bases[3] = '{24'h05a000, 24'h058000, 24'h050000};
      for (int k = 0; k < 3; k++) begin
         cmd(1'b1, ops[k], 24'h05a5a5, 32, 0, 1'b0, 8'h00);
         check(eq[0], {6'h00, k[1:0], bases[k]});
         check(bc >= 100 * (k + 1) && bc <= 100 * (k + 1) + 1, 1);
         check({eq.size(), latch}, 2);
      end
   endtask
   task automatic t_program();
      cmd(1'b1, OP_PAGE_PROGRAM, 24'h0012fe, 32, 3, 1'b0, 8'h10);  // page still erased
      check(wq.size(), 3);
      check(wq[0], 32'h00120012);
      check(wq[1], 32'h0012fe10);
      check(wq[2], 32'h0012ff11);
      check(bc >= 500 && bc <= 502, 1);
      check(latch, 0);
      cmd(1'b1, OP_PAGE_PROGRAM, 24'h000400, 32, 258, 1'b0, 8'h01);
      check(wq.size(), 256);
      check(wq[0], 32'h000400fe);
      check(wq[1], 32'h000401fd);
      check(wq[3], 32'h00040304);
   endtask
   task automatic t_quad();
      cmd(1'b1, OP_QUAD_PROGRAM, 24'h000300, 32, 1, 1'b1, 8'ha5);
      check({bc, latch}, 1);
      quad_en = 1'b1;
      cmd(1'b0, OP_QUAD_PROGRAM, 24'h000300, 32, 1, 1'b1, 8'ha5);
      check(wq.size(), 1);
      check(wq[0], 32'h000300a5);
   endtask
   task automatic end_of_test();
      if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(negedge mclk_i);
      sys_rst_i = 1'b0;
      t_refusals();
      t_erase();
      t_program();
      t_quad();
      end_of_test();
   end
   initial begin
      #2000000;
      fail_count++;
      end_of_test();
   end
endmodule
